// >>> verilog/lsx_consts.vh
// Constants for the load/store/transfer executor: APB map, opcodes, timing.
// Assumes a 200 MHz clock and word-addressed main memory with 16-bit words.
`ifndef LSX_CONSTS_VH
`define LSX_CONSTS_VH

// APB register byte addresses.
`define LSX_A_CTRL      12'h000
`define LSX_A_STATUS    12'h004
`define LSX_A_IP        12'h008
`define LSX_A_IWORD     12'h00C
`define LSX_A_GPR_BASE  12'h040
`define LSX_A_GPR_MASK  12'hFC3

// Status and control bit positions.
`define LSX_B_START     0
`define LSX_B_BUSY      0
`define LSX_B_OVERRUN   1

// Operation codes in instruction bits 15:8 (values are arbitrary).
`define LSX_OP_LD_DIR    8'h80
`define LSX_OP_LD_IMM    8'h81
`define LSX_OP_LD_SHORT  8'h82
`define LSX_OP_LD_PTR    8'h83
`define LSX_OP_ST_DIR    8'h84
`define LSX_OP_ST_INL    8'h85
`define LSX_OP_ST_SHORT  8'h86
`define LSX_OP_ST_PTR    8'h87
`define LSX_OP_LD_BYTE   8'h88
`define LSX_OP_ST_BYTE   8'h89
`define LSX_OP_BLD_DIR   8'h8A
`define LSX_OP_BLD_SHORT 8'h8B
`define LSX_OP_BLD_PTR   8'h8C
`define LSX_OP_BST_DIR   8'h8D
`define LSX_OP_BST_SHORT 8'h8E
`define LSX_OP_BST_PTR   8'h8F
`define LSX_OP_COPY      8'h90
`define LSX_OP_COPY_BNZ  8'h91

// Register numbers and fixed values.
`define LSX_R_SHORT     4'h1
`define LSX_R_LOW_BIT   4'h1
`define LSX_R_LAST_LO   4'h7
`define LSX_R_LAST_HI   4'hF
`define LSX_ONE         16'h0001
`define LSX_TWO         16'h0002
`define LSX_ZERO_BYTE   8'h00
`define LSX_CYC_SAT     12'hFFF

// Execution-time ceilings in ns and their cycle counts.
`define LSX_CLK_NS      5
`define LSX_T_PTR_NS    1870
`define LSX_T_DIR_NS    2400
`define LSX_T_INL_NS    1600
`define LSX_T_BLK_NS    3470
`define LSX_T_BDIR_NS   4000
`define LSX_T_EXTRA_NS  800
`define LSX_T_COPY_NS   800
`define LSX_T_CBNZ_NS   1600
`define LSX_CYC_PTR     (`LSX_T_PTR_NS / `LSX_CLK_NS)
`define LSX_CYC_DIR     (`LSX_T_DIR_NS / `LSX_CLK_NS)
`define LSX_CYC_INL     (`LSX_T_INL_NS / `LSX_CLK_NS)
`define LSX_CYC_BLK     (`LSX_T_BLK_NS / `LSX_CLK_NS)
`define LSX_CYC_BDIR    (`LSX_T_BDIR_NS / `LSX_CLK_NS)
`define LSX_CYC_EXTRA   (`LSX_T_EXTRA_NS / `LSX_CLK_NS)
`define LSX_CYC_COPY    (`LSX_T_COPY_NS / `LSX_CLK_NS)
`define LSX_CYC_CBNZ    (`LSX_T_CBNZ_NS / `LSX_CLK_NS)

`endif

// >>> verilog/lsx_exec.v
// Executor for the load, store and transfer instruction group.
// Assumes an APB master for control and a word memory that holds
// mem_req until a one-cycle mem_ack, with read data valid on that ack.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "lsx_consts.vh"

module lsx_exec (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [15:0] mem_rdata
);

  localparam S_IDLE = 3'd0;
  localparam S_F1   = 3'd1;
  localparam S_F2   = 3'd2;
  localparam S_EX   = 3'd3;
  localparam S_RD   = 3'd4;
  localparam S_WR   = 3'd5;
  localparam S_BLK  = 3'd6;
  localparam S_FIN  = 3'd7;

  reg [2:0]  state_reg;
  reg [15:0] ip_reg;
  reg [15:0] nip_reg;
  reg [15:0] iw0_reg;
  reg [15:0] iw1_reg;
  reg [3:0]  cur_reg;
  reg [3:0]  last_reg;
  reg        bsel_reg;
  reg [11:0] cyc_reg;
  reg        overrun_reg;
  reg [15:0] gpr [0:15];
  reg [31:0] rd_mux;
  reg [31:0] budget;
  integer    i;

  // ********************************************************************
  // Instruction fields and address forms
  // ********************************************************************
  // The opcode fills the high byte; both register fields sit in the low byte.
  wire [7:0]  op       = iw0_reg[15:8];
  wire [3:0]  dst      = iw0_reg[7:4];
  wire [3:0]  src      = iw0_reg[3:0];
  wire [7:0]  fetch_op = mem_rdata[15:8];
  // Direct forms read the source field as an index selector. Its top bit, the
  // indirect flag, is not followed, so chained addresses are never built.
  wire [2:0]  idx      = src[2:0];
  wire [15:0] idx_val  = (idx != 3'd0) ? gpr[{1'b0, idx}] : 16'h0000;
  wire [15:0] loc_dir  = iw1_reg + idx_val;
  wire [15:0] loc_sh   = gpr[`LSX_R_SHORT] + {12'h000, src};
  wire [15:0] loc_ptr  = gpr[src];
  // An odd pointer register names itself as both base and displacement.
  wire [3:0]  pair_low = src | `LSX_R_LOW_BIT;
  wire [15:0] disp     = gpr[pair_low];
  wire [15:0] ebw      = gpr[src] + {disp[15], disp[15:1]};
  wire [3:0]  last_r   = dst[3] ? `LSX_R_LAST_HI : `LSX_R_LAST_LO;
  wire [15:0] ip_one   = ip_reg + `LSX_ONE;
  wire [15:0] ip_two   = ip_reg + `LSX_TWO;
  // Forms that carry a second word, other than the inline store, fetch it before executing, so every
  // address sum below sees a settled operand word.
  wire        need_w2  = (fetch_op == `LSX_OP_LD_DIR) || (fetch_op == `LSX_OP_LD_IMM) ||
                         (fetch_op == `LSX_OP_ST_DIR) || (fetch_op == `LSX_OP_BLD_DIR) ||
                         (fetch_op == `LSX_OP_BST_DIR) || (fetch_op == `LSX_OP_COPY_BNZ);
  wire [15:0] byte_sel = bsel_reg ? {8'h00, mem_rdata[7:0]} : {8'h00, mem_rdata[15:8]};
  wire [15:0] byte_mrg = bsel_reg ? {mem_rdata[15:8], gpr[dst][7:0]}
                                  : {gpr[dst][7:0], mem_rdata[7:0]};
  wire        is_load  = (op == `LSX_OP_BLD_DIR) || (op == `LSX_OP_BLD_SHORT) ||
                         (op == `LSX_OP_BLD_PTR);
  wire        blk_dir  = (op == `LSX_OP_BLD_DIR) || (op == `LSX_OP_BST_DIR);
  wire        blk_sh   = (op == `LSX_OP_BLD_SHORT) || (op == `LSX_OP_BST_SHORT);
  // Registers moved beyond the first earn the per-word time allowance.
  wire [31:0] extra    = {28'h0000_000, last_reg - dst} * `LSX_CYC_EXTRA;

  // ********************************************************************
  // APB decode
  // ********************************************************************
  wire busy     = (state_reg != S_IDLE);
  wire acc      = psel & penable & pready;
  wire wr       = acc & pwrite;
  wire gpr_hit  = ((paddr & `LSX_A_GPR_MASK) == `LSX_A_GPR_BASE);
  wire reg_hit  = (paddr == `LSX_A_CTRL) || (paddr == `LSX_A_STATUS) ||
                  (paddr == `LSX_A_IP) || (paddr == `LSX_A_IWORD) || gpr_hit;
  wire start    = wr & (paddr == `LSX_A_CTRL) & pwdata[`LSX_B_START];

  always @* begin
    rd_mux = 32'h0000_0000;
    if (gpr_hit) begin
      rd_mux = {16'h0000, gpr[paddr[5:2]]};
    end else begin
      case (paddr)
        `LSX_A_STATUS: rd_mux = {30'h0000_0000, overrun_reg, busy};
        `LSX_A_IP:     rd_mux = {16'h0000, ip_reg};
        `LSX_A_IWORD:  rd_mux = {16'h0000, iw0_reg};
        default:       rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Ceiling per instruction; forms with no printed time get the 2.4 us
  // single-word or 4.0 us block figure so the check never false-fires.
  always @* begin
    case (op)
      `LSX_OP_LD_PTR, `LSX_OP_ST_SHORT,
      `LSX_OP_ST_PTR:    budget = `LSX_CYC_PTR;
      `LSX_OP_ST_INL:    budget = `LSX_CYC_INL;
      `LSX_OP_COPY:      budget = `LSX_CYC_COPY;
      `LSX_OP_COPY_BNZ:  budget = `LSX_CYC_CBNZ;
      `LSX_OP_BLD_PTR, `LSX_OP_BST_SHORT,
      `LSX_OP_BST_PTR:   budget = `LSX_CYC_BLK + extra;
      `LSX_OP_BST_DIR, `LSX_OP_BLD_DIR,
      `LSX_OP_BLD_SHORT: budget = `LSX_CYC_BDIR + extra;
      default:           budget = `LSX_CYC_DIR;
    endcase
  end

  // ********************************************************************
  // Bus slave and execution sequencer
  // ********************************************************************
  always @(posedge clk) begin
    if (rst) begin
      state_reg   <= S_IDLE;
      ip_reg      <= 16'h0000;
      nip_reg     <= 16'h0000;
      iw0_reg     <= 16'h0000;
      iw1_reg     <= 16'h0000;
      cur_reg     <= 4'h0;
      last_reg    <= 4'h0;
      bsel_reg    <= 1'b0;
      cyc_reg     <= 12'h000;
      overrun_reg <= 1'b0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 16'h0000;
      mem_wdata   <= 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        gpr[i] <= 16'h0000;
      end
    end else begin
      // One wait state: data and error are latched as pready rises.
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= rd_mux;
        pslverr <= ~reg_hit;
      end
      // Software may only touch the pointer and registers while idle.
      if (wr & ~busy & gpr_hit) begin
        gpr[paddr[5:2]] <= pwdata[15:0];
      end
      if (wr & ~busy & (paddr == `LSX_A_IP)) begin
        ip_reg <= pwdata[15:0];
      end
      if (wr & (paddr == `LSX_A_STATUS) & pwdata[`LSX_B_OVERRUN]) begin
        overrun_reg <= 1'b0;
      end
      if (busy && cyc_reg != `LSX_CYC_SAT) begin
        cyc_reg <= cyc_reg + 12'h001;
      end

      case (state_reg)
        S_IDLE: begin
          if (start) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            mem_addr  <= ip_reg;
            cyc_reg   <= 12'h000;
            state_reg <= S_F1;
          end
        end
        S_F1: begin
          if (mem_ack) begin
            iw0_reg <= mem_rdata;
            if (need_w2) begin
              mem_addr  <= ip_one;
              state_reg <= S_F2;
            end else begin
              mem_req   <= 1'b0;
              state_reg <= S_EX;
            end
          end
        end
        S_F2: begin
          if (mem_ack) begin
            iw1_reg   <= mem_rdata;
            mem_req   <= 1'b0;
            state_reg <= S_EX;
          end
        end
        S_EX: begin
          nip_reg  <= ip_one;
          // Every form starts from the word after its first word; the case
          // below only overrides the advance for two-word forms and branches.
          cur_reg  <= dst;
          last_reg <= last_r;
          bsel_reg <= disp[0];
          mem_we   <= 1'b0;
          case (op)
            `LSX_OP_LD_IMM: begin
              gpr[dst]  <= iw1_reg;
              nip_reg   <= ip_two;
              state_reg <= S_FIN;
            end
            `LSX_OP_COPY: begin
              // Equal fields simply copy a register onto itself.
              gpr[dst]  <= gpr[src];
              state_reg <= S_FIN;
            end
            `LSX_OP_COPY_BNZ: begin
              // The copied value is the source word, so the test reads it directly.
              gpr[dst]  <= gpr[src];
              nip_reg   <= (gpr[src] != 16'h0000) ? iw1_reg : ip_two;
              state_reg <= S_FIN;
            end
            `LSX_OP_LD_DIR, `LSX_OP_LD_SHORT, `LSX_OP_LD_PTR, `LSX_OP_LD_BYTE: begin
              mem_req   <= 1'b1;
              mem_addr  <= (op == `LSX_OP_LD_DIR) ? loc_dir :
                           (op == `LSX_OP_LD_SHORT) ? loc_sh :
                           (op == `LSX_OP_LD_PTR) ? loc_ptr : ebw;
              nip_reg   <= (op == `LSX_OP_LD_DIR) ? ip_two : ip_one;
              state_reg <= S_RD;
            end
            `LSX_OP_ST_BYTE: begin
              // Read the word first, then write it back merged; the request
              // stays up between the two halves of the update.
              mem_req   <= 1'b1;
              mem_addr  <= ebw;
              state_reg <= S_RD;
            end
            `LSX_OP_ST_DIR, `LSX_OP_ST_INL, `LSX_OP_ST_SHORT, `LSX_OP_ST_PTR: begin
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_wdata <= gpr[dst];
              mem_addr  <= (op == `LSX_OP_ST_DIR) ? loc_dir :
                           (op == `LSX_OP_ST_INL) ? ip_one :
                           (op == `LSX_OP_ST_SHORT) ? loc_sh : loc_ptr;
              nip_reg   <= ((op == `LSX_OP_ST_DIR) || (op == `LSX_OP_ST_INL)) ? ip_two : ip_one;
              state_reg <= S_WR;
            end
            `LSX_OP_BLD_DIR, `LSX_OP_BLD_SHORT, `LSX_OP_BLD_PTR,
            `LSX_OP_BST_DIR, `LSX_OP_BST_SHORT, `LSX_OP_BST_PTR: begin
              // A store block preloads its first word here; later words follow
              // each acknowledge without dropping the request.
              mem_req   <= 1'b1;
              mem_we    <= ~is_load;
              mem_wdata <= gpr[dst];
              mem_addr  <= blk_dir ? loc_dir : (blk_sh ? loc_sh : loc_ptr);
              nip_reg   <= blk_dir ? ip_two : ip_one;
              state_reg <= S_BLK;
            end
            default: begin
              // Codes outside this group retire as no-operations.
              state_reg <= S_FIN;
            end
          endcase
        end
        S_RD: begin
          if (mem_ack) begin
            // The read data stands only with the acknowledge, so it is used now.
            if (op == `LSX_OP_ST_BYTE) begin
              mem_we    <= 1'b1;
              mem_wdata <= byte_mrg;
              state_reg <= S_WR;
            end else begin
              mem_req   <= 1'b0;
              gpr[dst]  <= (op == `LSX_OP_LD_BYTE) ? byte_sel : mem_rdata;
              state_reg <= S_FIN;
            end
          end
        end
        S_WR: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            state_reg <= S_FIN;
          end
        end
        S_BLK: begin
          if (mem_ack) begin
            if (is_load) begin
              gpr[cur_reg] <= mem_rdata;
            end
            if (cur_reg == last_reg) begin
              mem_req   <= 1'b0;
              mem_we    <= 1'b0;
              state_reg <= S_FIN;
            end else begin
              cur_reg   <= cur_reg + 4'h1;
              mem_addr  <= mem_addr + `LSX_ONE;
              mem_wdata <= gpr[cur_reg + 4'h1];
            end
          end
        end
        S_FIN: begin
          ip_reg    <= nip_reg;
          state_reg <= S_IDLE;
          // Flags an instruction slower than its ceiling, usually a slow memory.
          if ({20'h0_0000, cyc_reg} > budget) begin
            overrun_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> sim/lsx_exec_chk.sv
// Checker for the executor's APB and memory ports.
// Assumes it is bound to lsx_exec and sees only that module's ports.
`timescale 1ns/100ps
`include "lsx_consts.vh"
module lsx_exec_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_rdata
);
  logic        fetch_pend;
  logic [15:0] fetch_addr;
  logic [15:0] ip_written;
  wire         wr_done = psel && penable && pready && pwrite;
  wire         mapped  = paddr[1:0] == 2'h0 && (paddr < 12'h010 || paddr[11:6] == 6'h01);
  // The first request after a start is the fetch of the first word.
  always @(posedge clk) begin
    if (rst) begin
      fetch_pend <= 1'b0;
      fetch_addr <= 16'h0000;
      ip_written <= 16'h0000;
    end else begin
      if (wr_done && paddr == `LSX_A_IP) ip_written <= pwdata[15:0];
      if (wr_done && paddr == `LSX_A_CTRL && pwdata[0]) fetch_pend <= 1'b1;
      else if (mem_ack && fetch_pend) begin
        fetch_pend <= 1'b0;
        fetch_addr <= mem_addr;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_xfer: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_err_decode: assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
  a_err_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("error read data not zero");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request changed early");
  a_store_ascend: assert property (mem_ack && mem_we ##1 mem_req && mem_we |->
    mem_addr == $past(mem_addr) + 16'h0001) else $error("block store address not ascending");
  a_fetch_ip: assert property (fetch_pend && mem_req |-> !mem_we && mem_addr == ip_written)
    else $error("first fetch not at pointer");
  a_inline_store: assert property (mem_ack && fetch_pend && mem_rdata[15:8] == `LSX_OP_ST_INL
    |=> ##[0:300] (mem_req && mem_we && mem_addr == fetch_addr + 16'h0001))
    else $error("inline store missed second word");
endmodule

// >>> sim/lsx_mem_model.sv
// Word memory model on the executor's far side.
// Assumes requests are held until its one-cycle acknowledge.
`timescale 1ns/100ps
module lsx_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_cnt;
  logic [1:0]  wait_len;
  // The wait steps 0..3 and wraps, one step per access, so prompt and slow answers both occur.
  // Outside an acknowledge the read data toggles, so stale data never looks valid.
  always @(posedge clk) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      wait_len  <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && wait_cnt == wait_len) begin
      mem_ack  <= 1'b1;
      wait_cnt <= 2'h0;
      wait_len <= wait_len + 2'h1;
      if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the load, store and transfer executor.
// Assumes the memory model answers the memory port; APB is driven here.
`timescale 1ns/100ps
`include "lsx_consts.vh"
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready, pslverr, mem_req, mem_we, mem_ack;
  wire  [15:0] mem_addr, mem_wdata, mem_rdata;
  int          miscompares = 0, checked = 0, i;
  logic [63:0] exp_q [$];
  logic [63:0] e;
  logic [31:0] q;
  logic        err;
  logic [15:0] rnd = 16'h64EA, v, w;
  always #2.5 clk = ~clk;
  lsx_exec i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  lsx_mem_model i_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  function automatic logic [15:0] r();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin miscompares++; print_verdict; end
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    exp_q.push_back({32'hFFFF_FFFF, x});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task g(input logic [3:0] n, input logic [15:0] x);
    apb(1'b1, `LSX_A_GPR_BASE | {6'h00, n, 2'h0}, {16'h0000, x});
  endtask
  task rg(input logic [3:0] n, input logic [15:0] x);
    rd(`LSX_A_GPR_BASE | {6'h00, n, 2'h0}, {16'h0000, x});
  endtask
  task mc(input logic [7:0] a, input logic [15:0] x);
    cmp({16'h0000, i_mem.mem[a]}, {16'h0000, x}, "memory word");
  endtask
  // Runs one instruction and checks that it ended within its time ceiling.
  task exe(input logic [15:0] ip, input logic [15:0] w1, input logic [15:0] w2);
    int k;
    i_mem.mem[ip[7:0]] = w1;
    i_mem.mem[ip[7:0] + 8'h01] = w2;
    apb(1'b1, `LSX_A_IP, {16'h0000, ip});
    apb(1'b1, `LSX_A_CTRL, 32'h0000_0001);
    for (k = 0; k < 600; k++) begin
      exp_q.push_back(64'h0);
      apb(1'b0, `LSX_A_STATUS, 32'h0000_0000);
      if (q[0] === 1'b0) break;
    end
    if (k == 600) begin miscompares++; print_verdict; end
    cmp(q, 32'h0000_0000, "busy or overrun");
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      if (e[63:32] != 32'h0) cmp(prdata & e[63:32], e[31:0], "register read");
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`LSX_A_STATUS, 0); rd(`LSX_A_IP, 0); rg(4'hF, 16'h0000);
    rd(12'h020, 32'h0000_0000); cmp(32'(err), 1, "unmapped");
    $display("test reset and map done");
    v = r(); exe(16'h0010, {`LSX_OP_LD_IMM, 8'h50}, v); rg(5, v);
    rd(`LSX_A_IP, 32'h0000_0012);
    g(3, 16'h0004); v = r(); w = r(); i_mem.mem[8'h34] = v; i_mem.mem[8'h30] = w;
    exe(16'h0014, {`LSX_OP_LD_DIR, 8'h23}, 16'h0030); rg(2, v);
    exe(16'h0014, {`LSX_OP_LD_DIR, 8'h20}, 16'h0030); rg(2, w);
    g(15, 16'h0050); v = r(); i_mem.mem[8'h50] = v;
    exe(16'h0018, {`LSX_OP_LD_PTR, 8'h4F}, 16'h0000); rg(4, v);
    rd(`LSX_A_IP, 32'h0000_0019);
    $display("test loads done");
    g(1, 16'h0060); v = r(); g(6, v);
    exe(16'h001A, {`LSX_OP_ST_SHORT, 8'h6F}, 16'h0000); mc(8'h6F, v);
    v = r(); g(7, v); exe(16'h0020, {`LSX_OP_ST_INL, 8'h70}, 16'hBEEF); mc(8'h21, v);
    rd(`LSX_A_IP, 32'h0000_0022);
    v = r(); g(8, v); exe(16'h0024, {`LSX_OP_ST_DIR, 8'h80}, 16'h0068); mc(8'h68, v);
    v = r(); g(9, v); g(10, 16'h006A);
    exe(16'h0026, {`LSX_OP_ST_PTR, 8'h9A}, 16'h0000); mc(8'h6A, v);
    $display("test stores done");
    g(12, 16'h0070); g(13, 16'hFFFD); v = r(); i_mem.mem[8'h6E] = v;
    exe(16'h0028, {`LSX_OP_LD_BYTE, 8'h2C}, 16'h0000); rg(2, {8'h00, v[7:0]});
    g(13, 16'h0004); v = r(); i_mem.mem[8'h06] = v;
    exe(16'h0028, {`LSX_OP_LD_BYTE, 8'h2D}, 16'h0000); rg(2, {8'h00, v[15:8]});
    v = r(); w = r(); g(3, v); i_mem.mem[8'h72] = w;
    exe(16'h0028, {`LSX_OP_ST_BYTE, 8'h3C}, 16'h0000); mc(8'h72, {v[7:0], w[7:0]});
    $display("test bytes done");
    v = r(); w = r(); g(11, 16'h0080); i_mem.mem[8'h80] = v; i_mem.mem[8'h81] = w;
    exe(16'h0030, {`LSX_OP_BLD_PTR, 8'h6B}, 16'h0000); rg(6, v); rg(7, w);
    g(1, 16'h0090); v = r();
    for (i = 13; i < 16; i++) g(4'(i), v + 16'(i));
    exe(16'h0030, {`LSX_OP_BST_SHORT, 8'hD2}, 16'h0000);
    for (i = 0; i < 3; i++) mc(8'h92 + 8'(i), v + 16'(13 + i));
    exe(16'h0030, {`LSX_OP_LD_SHORT, 8'h53}, 16'h0000); rg(5, v + 16'd14);
    exe(16'h0030, {`LSX_OP_BST_PTR, 8'hEB}, 16'h0000); mc(8'h81, v + 16'd15);
    exe(16'h0030, {`LSX_OP_BLD_DIR, 8'hE0}, 16'h0092); rg(14, v + 16'd13);
    exe(16'h0030, {`LSX_OP_BLD_SHORT, 8'h72}, 16'h0000); rg(7, v + 16'd13);
    // The direct block load above left register 15 holding the second stored word.
    exe(16'h0030, {`LSX_OP_BST_DIR, 8'h80}, 16'h00B0); mc(8'hB7, v + 16'd14);
    $display("test blocks done");
    v = r() | 16'h0001; g(9, v);
    exe(16'h0040, {`LSX_OP_COPY, 8'h99}, 16'h0000); rg(9, v);
    exe(16'h0040, {`LSX_OP_COPY, 8'h39}, 16'h0000); rg(3, v);
    exe(16'h0040, {`LSX_OP_COPY_BNZ, 8'h49}, 16'h00A0); rg(4, v);
    rd(`LSX_A_IP, 32'h0000_00A0);
    exe(16'h0040, {`LSX_OP_COPY_BNZ, 8'h50}, 16'h00A0); rg(5, 16'h0000);
    rd(`LSX_A_IP, 32'h0000_0042);
    $display("test transfers done");
    repeat (4) @(posedge clk);
    print_verdict;
  end
endmodule
bind lsx_exec lsx_exec_chk i_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
